// [verilog/rate_adapter_consts.vh]
`ifndef RATE_ADAPTER_CONSTS_VH
`define RATE_ADAPTER_CONSTS_VH

// ********************************
// register addresses (5-bit port)
// ********************************
`define A_DEC_PAIR 5'h00
`define A_DEC_BIT 5'h00
`define A_ENC_PAIR 5'h02
`define A_STATUS 5'h03
`define A_ENC_BIT 5'h05
`define A_CTRL 5'h06
`define A_DEC_IN_STB 5'h0e
`define A_DEC_OUT_STB 5'h0f
`define A_ENC_IN_STB 5'h11
`define A_ENC_OUT_STB 5'h12

// ********************************
// field positions
// ********************************
`define F_FIRST_SYM 0
`define F_SECOND_SYM 1
`define F_FIRST_ERASE 2
`define F_SECOND_ERASE 3
`define F_CTRL_RESET 2

// ********************************
// reset values and encodings
// ********************************
`define CTRL_RESET_VAL 8'h00
`define RATE_HALF 2'h0
`define RATE_3Q 2'h1
`define RATE_7E 2'h2
`define LAST_3Q 3'h2
`define LAST_7E 3'h6
`define BM_MATCH 3'h0
`define BM_ERASE 3'h1
`define BM_MISS 3'h2

`endif

// [verilog/pair_buffer.v]
`timescale 1ns/100ps

// ********************************
// shift buffer, head is a flop
// ********************************
module pair_buffer #(
    parameter WIDTH = 2,
    parameter DEPTH = 2,
    parameter CW = 2
) (
    input wire ref_clk,
    input wire rst,
    input wire in_valid,
    input wire [WIDTH-1:0] in_data,
    output wire in_ready,
    output wire out_valid,
    output wire [WIDTH-1:0] out_data,
    input wire out_ready
);
    reg [WIDTH-1:0] data_q [0:DEPTH-1]; // entry 0 faces the reader
    reg [CW-1:0] count_q; // occupied entries
    reg valid_q; // registered non-empty
    wire push;
    wire pop;
    wire [CW-1:0] wr_idx; // slot taken by a push
    integer i;

    assign in_ready = (count_q != DEPTH[CW-1:0]);
    assign out_valid = valid_q;
    assign out_data = data_q[0];
    assign push = in_valid && in_ready;
    assign pop = valid_q && out_ready;
    assign wr_idx = count_q - {{(CW-1){1'b0}}, pop};

    // storage shifts toward the head on every pop
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                data_q[i] <= {WIDTH{1'b0}};
            end
        end else begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                if (push && wr_idx == i[CW-1:0]) begin
                    data_q[i] <= in_data;
                end else if (pop && i < DEPTH - 1) begin
                    data_q[i] <= data_q[i+1];
                end
            end
        end
    end

    // occupancy; full stalls the filler through in_ready
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_q <= {CW{1'b0}};
            valid_q <= 1'b0;
        end else begin
            count_q <= wr_idx + {{(CW-1){1'b0}}, push};
            valid_q <= (wr_idx + {{(CW-1){1'b0}}, push}) != {CW{1'b0}};
        end
    end
endmodule

// [verilog/acs_unit.v]
`timescale 1ns/100ps
`include "rate_adapter_consts.vh"

// ********************************
// add-compare-select for one state
// ********************************
module acs_unit #(
    parameter K = 7,
    parameter MW = 8,
    parameter DEPTH = 32,
    parameter [K-1:0] G_FIRST = 7'h79,
    parameter [K-1:0] G_SECOND = 7'h5b,
    parameter NEXT = 0
) (
    input wire [MW-1:0] metric_a,
    input wire [MW-1:0] metric_b,
    input wire [DEPTH-1:0] surv_a,
    input wire [DEPTH-1:0] surv_b,
    input wire [3:0] pair,
    output wire [MW-1:0] metric_out,
    output wire [DEPTH-1:0] surv_out
);
    localparam [K-2:0] NS = NEXT[K-2:0]; // this state's index
    // code words from either predecessor into this state
    localparam [K-1:0] VA = {1'b0, NS};
    localparam [K-1:0] VB = {1'b1, NS};

    // per-symbol cost: erased sits midway between hit and miss
    function [2:0] cost;
        input rx;
        input er;
        input exp;
        begin
            if (er) cost = `BM_ERASE;
            else if (rx == exp) cost = `BM_MATCH;
            else cost = `BM_MISS;
        end
    endfunction

    wire [2:0] bm_a;
    wire [2:0] bm_b;
    wire [MW-1:0] sum_a;
    wire [MW-1:0] sum_b;
    wire take_b;

    assign bm_a = cost(pair[`F_FIRST_SYM], pair[`F_FIRST_ERASE],
        ^(VA & G_FIRST)) + cost(pair[`F_SECOND_SYM],
        pair[`F_SECOND_ERASE], ^(VA & G_SECOND));
    assign bm_b = cost(pair[`F_FIRST_SYM], pair[`F_FIRST_ERASE],
        ^(VB & G_FIRST)) + cost(pair[`F_SECOND_SYM],
        pair[`F_SECOND_ERASE], ^(VB & G_SECOND));
    assign sum_a = metric_a + {{(MW-3){1'b0}}, bm_a};
    assign sum_b = metric_b + {{(MW-3){1'b0}}, bm_b};
    // ties keep the lower predecessor
    assign take_b = sum_b < sum_a;
    assign metric_out = take_b ? sum_b : sum_a;
    assign surv_out = {take_b ? surv_b[DEPTH-2:0] : surv_a[DEPTH-2:0],
        NS[0]};
endmodule

// [verilog/punctured_rate_adapter.v]
`timescale 1ns/100ps
`include "rate_adapter_consts.vh"

// ********************************
// Notes on behaviour
// - rate 3/4 drops two of six bits
// - erased symbol costs midway, no information
// - strobes 11 then 12 step encoder
// - both code bits readable at 02
// - strobes 0e then 0f step decoder
// - decoded bit in bit 0 at 00
// - lock outputs driven even without auto sync
// - codec reset spares host registers
// - rate 7/8 drops six of fourteen bits
// ********************************
module punctured_rate_adapter #(
    parameter K = 7,
    parameter MW = 8,
    parameter DEPTH = 32,
    parameter [K-1:0] G_FIRST = 7'h79,
    parameter [K-1:0] G_SECOND = 7'h5b,
    parameter [15:0] LOCK_WIN = 16'h0040,
    parameter [15:0] LOCK_LIMIT = 16'h0018,
    parameter BUF_DEPTH = 2
) (
    input wire ref_clk,
    input wire rst,
    input wire [4:0] addr,
    input wire [7:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output wire [7:0] rd_data,
    input wire sym_ready,
    output wire sym_valid,
    output wire [1:0] sym_data,
    output wire lock_lost_flag,
    output wire lock_held_flag
);
    localparam SW = K - 1; // state width
    localparam NS = 1 << SW; // trellis states

    // ********************************
    // host-visible registers
    // ********************************
    reg [7:0] ctrl_q; // rate and codec reset
    reg [3:0] dec_pair_q; // received pair and erase flags
    reg enc_bit_q; // information bit to encode
    reg [1:0] enc_pair_q; // last code pair
    reg dec_bit_q; // last decoded bit
    reg [7:0] rd_data_q; // read answer

    // ********************************
    // codec state
    // ********************************
    reg enc_in_q; // bit latched by encoder input strobe
    reg [3:0] dec_in_q; // pair latched by decoder input strobe
    reg [SW-1:0] sr_q; // encoder shift register
    reg [2:0] tx_step_q; // transmit_step_count
    reg [2:0] rx_step_q; // receive step count
    reg kept_q; // stored second code bit
    reg pend_q; // symbol waiting for the buffer
    reg [1:0] pend_sym_q; // that symbol
    reg [1:0] rate_prev_q; // rate seen last cycle
    reg [MW-1:0] pm_q [0:NS-1]; // path metrics
    reg [DEPTH-1:0] surv_q [0:NS-1]; // survivor bits
    reg [15:0] err_acc_q; // metric growth in window
    reg [15:0] win_cnt_q; // decode steps in window
    reg lost_q; // lock_lost_flag
    reg held_q; // lock_held_flag

    // decoded strobes
    reg wr_pair;
    reg wr_ebit;
    reg wr_ctrl;
    reg stb_din;
    reg stb_dout;
    reg stb_ein;
    reg stb_eout;

    wire [1:0] rate;
    wire codec_rst;
    wire punct;
    wire step_clr;
    wire [2:0] last_step;
    wire buf_ready;
    wire [MW-1:0] pm_new [0:NS-1];
    wire [DEPTH-1:0] surv_new [0:NS-1];

    assign rate = ctrl_q[1:0];
    assign codec_rst = ctrl_q[`F_CTRL_RESET];
    assign punct = (rate == `RATE_3Q) || (rate == `RATE_7E);
    // counters restart on codec reset or a new rate
    assign step_clr = codec_rst || (rate != rate_prev_q);
    assign last_step = (rate == `RATE_7E) ? `LAST_7E : `LAST_3Q;

    // ********************************
    // address decode
    // ********************************
    // write data is ignored by the four strobe addresses
    always @* begin
        wr_pair = 1'b0;
        wr_ebit = 1'b0;
        wr_ctrl = 1'b0;
        stb_din = 1'b0;
        stb_dout = 1'b0;
        stb_ein = 1'b0;
        stb_eout = 1'b0;
        if (wr_en) begin
            if (addr == `A_DEC_PAIR) begin
                wr_pair = 1'b1;
            end else if (addr == `A_ENC_BIT) begin
                wr_ebit = 1'b1;
            end else if (addr == `A_CTRL) begin
                wr_ctrl = 1'b1;
            end else if (addr == `A_DEC_IN_STB) begin
                stb_din = 1'b1;
            end else if (addr == `A_DEC_OUT_STB) begin
                stb_dout = 1'b1;
            end else if (addr == `A_ENC_IN_STB) begin
                stb_ein = 1'b1;
            end else if (addr == `A_ENC_OUT_STB) begin
                stb_eout = 1'b1;
            end
        end
    end

    // ********************************
    // encoder and puncture selection
    // ********************************
    wire [K-1:0] enc_vec;
    wire c_first; // first_code_bit
    wire c_second; // second_code_bit
    wire enc_go; // an encoder step runs this cycle
    reg sym_go; // this step emits a symbol
    reg keep_now; // this step stores the second bit
    reg [1:0] sym_next; // {second, first} symbol bits

    assign enc_vec = {sr_q, enc_in_q};
    assign c_first = ^(enc_vec & G_FIRST);
    assign c_second = ^(enc_vec & G_SECOND);
    // a step is refused while the last symbol still waits
    assign enc_go = stb_eout && !codec_rst && !pend_q;

    // which bits leave at this step
    always @* begin
        sym_go = 1'b1;
        keep_now = 1'b0;
        sym_next = {c_second, c_first};
        if (punct) begin
            if (tx_step_q == 3'h0) begin
                sym_go = 1'b1;
            end else if (tx_step_q[0]) begin
                sym_go = 1'b0;
                keep_now = 1'b1;
            end else if (rate == `RATE_7E && tx_step_q == 3'h2) begin
                sym_next = {kept_q, c_second};
            end else begin
                sym_next = {kept_q, c_first};
            end
        end
    end

    // encoder shift, puncture counter and symbol hand-off
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sr_q <= {SW{1'b0}};
            enc_in_q <= 1'b0;
            enc_pair_q <= 2'h0;
            tx_step_q <= 3'h0;
            kept_q <= 1'b0;
            pend_q <= 1'b0;
            pend_sym_q <= 2'h0;
        end else begin
            if (pend_q && buf_ready) begin
                pend_q <= 1'b0;
            end
            if (stb_ein) begin
                enc_in_q <= enc_bit_q;
            end
            if (codec_rst) begin
                sr_q <= {SW{1'b0}};
            end else if (enc_go) begin
                sr_q <= enc_vec[SW-1:0];
                enc_pair_q <= {c_second, c_first};
                if (keep_now) begin
                    kept_q <= c_second;
                end
                if (sym_go) begin
                    pend_q <= 1'b1;
                    pend_sym_q <= sym_next;
                end
            end
            if (step_clr || !punct) begin
                tx_step_q <= 3'h0;
            end else if (enc_go) begin
                if (tx_step_q == last_step) begin
                    tx_step_q <= 3'h0;
                end else begin
                    tx_step_q <= tx_step_q + 3'h1;
                end
            end
        end
    end

    // ********************************
    // symbol buffer toward the modulator
    // ********************************
    pair_buffer #(
        .WIDTH(2),
        .DEPTH(BUF_DEPTH),
        .CW(2)
    ) sym_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(pend_q),
        .in_data(pend_sym_q),
        .in_ready(buf_ready),
        .out_valid(sym_valid),
        .out_data(sym_data),
        .out_ready(sym_ready)
    );

    // ********************************
    // viterbi decoder
    // ********************************
    genvar s;
    generate
        for (s = 0; s < NS; s = s + 1) begin : acs
            acs_unit #(
                .K(K),
                .MW(MW),
                .DEPTH(DEPTH),
                .G_FIRST(G_FIRST),
                .G_SECOND(G_SECOND),
                .NEXT(s)
            ) unit (
                .metric_a(pm_q[s >> 1]),
                .metric_b(pm_q[(s >> 1) + NS / 2]),
                .surv_a(surv_q[s >> 1]),
                .surv_b(surv_q[(s >> 1) + NS / 2]),
                .pair(dec_in_q),
                .metric_out(pm_new[s]),
                .surv_out(surv_new[s])
            );
        end
    endgenerate

    // best state; its minimum is also the growth since last step
    reg [MW-1:0] pm_min;
    reg [SW-1:0] best;
    integer i;
    always @* begin
        pm_min = pm_q[0];
        best = {SW{1'b0}};
        for (i = 1; i < NS; i = i + 1) begin
            if (pm_q[i] < pm_min) begin
                pm_min = pm_q[i];
                best = i[SW-1:0];
            end
        end
    end

    wire dec_go;
    integer j; // own index, so the clocked loop shares nothing with i
    assign dec_go = stb_dout && !codec_rst;

    // metric update, less the old minimum, so the new minimum is this step's growth
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (j = 0; j < NS; j = j + 1) begin
                pm_q[j] <= {MW{1'b0}};
                surv_q[j] <= {DEPTH{1'b0}};
            end
            dec_in_q <= 4'h0;
            dec_bit_q <= 1'b0;
        end else begin
            if (stb_din) begin
                dec_in_q <= dec_pair_q;
            end
            for (j = 0; j < NS; j = j + 1) begin
                if (codec_rst) begin
                    pm_q[j] <= {MW{1'b0}};
                end else if (dec_go) begin
                    pm_q[j] <= pm_new[j] - pm_min;
                    surv_q[j] <= surv_new[j];
                end
            end
            if (dec_go) begin
                dec_bit_q <= surv_q[best][DEPTH-1];
            end
        end
    end

    // depuncture counter: one decode per step; host erases nothing at 0, the first bit at odd steps
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rx_step_q <= 3'h0;
        end else if (step_clr || !punct) begin
            rx_step_q <= 3'h0;
        end else if (dec_go) begin
            if (rx_step_q == last_step) begin
                rx_step_q <= 3'h0;
            end else begin
                rx_step_q <= rx_step_q + 3'h1;
            end
        end
    end

    // ********************************
    // lock monitor
    // ********************************
    // heavy metric growth over a window means lost lock; an
    // outside latch may hold the result for the host
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            err_acc_q <= 16'h0000;
            win_cnt_q <= 16'h0000;
            lost_q <= 1'b0;
            held_q <= 1'b0;
        end else if (codec_rst) begin
            err_acc_q <= 16'h0000;
            win_cnt_q <= 16'h0000;
        end else if (dec_go) begin
            if (win_cnt_q == LOCK_WIN - 16'h0001) begin
                win_cnt_q <= 16'h0000;
                err_acc_q <= 16'h0000;
                lost_q <= err_acc_q > LOCK_LIMIT;
                held_q <= err_acc_q <= LOCK_LIMIT;
            end else begin
                win_cnt_q <= win_cnt_q + 16'h0001;
                err_acc_q <= err_acc_q + {{(16-MW){1'b0}}, pm_min};
            end
        end
    end

    // ********************************
    // host registers and read port
    // ********************************
    // codec reset leaves these untouched on purpose
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CTRL_RESET_VAL;
            dec_pair_q <= 4'h0;
            enc_bit_q <= 1'b0;
            rate_prev_q <= `RATE_HALF;
            rd_data_q <= 8'h00;
        end else begin
            rate_prev_q <= rate;
            if (wr_ctrl) begin
                ctrl_q <= wr_data;
            end
            if (wr_pair) begin
                dec_pair_q <= wr_data[3:0];
            end
            if (wr_ebit) begin
                enc_bit_q <= wr_data[0];
            end
            if (rd_en) begin
                if (addr == `A_DEC_BIT) begin
                    rd_data_q <= {7'h00, dec_bit_q};
                end else if (addr == `A_ENC_PAIR) begin
                    rd_data_q <= {6'h00, enc_pair_q};
                end else if (addr == `A_STATUS) begin
                    rd_data_q <= {pend_q, lost_q, rx_step_q, tx_step_q};
                end else if (addr == `A_CTRL) begin
                    rd_data_q <= ctrl_q;
                end else begin
                    rd_data_q <= 8'h00;
                end
            end
        end
    end

    assign rd_data = rd_data_q;
    assign lock_lost_flag = lost_q;
    assign lock_held_flag = held_q;
endmodule

// [tb/punctured_rate_adapter_properties.sv]
`timescale 1ns/100ps

// ****
// port checks for the rate adapter
// ****
module punctured_rate_adapter_properties (
    input wire ref_clk,
    input wire rst,
    input wire [4:0] addr,
    input wire [7:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] rd_data,
    input wire sym_ready,
    input wire sym_valid,
    input wire [1:0] sym_data,
    input wire lock_lost_flag,
    input wire lock_held_flag
);
    reg [2:0] ctrl_q; // shadow of rate and codec reset bits

    // shadow follows host writes to the control register
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= 3'h0;
        end else if (wr_en && addr == 5'h06) begin
            ctrl_q <= wr_data[2:0];
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_dec_bit;
        rd_en && addr == 5'h00 |=> rd_data[7:1] == 7'h00;
    endproperty
    a_dec_bit: assert property (p_dec_bit)
        else $error("decoded bit read has stray bits");
    property p_enc_pair;
        rd_en && addr == 5'h02 |=> rd_data[7:2] == 6'h00;
    endproperty
    a_enc_pair: assert property (p_enc_pair)
        else $error("code pair read has stray bits");
    property p_rd_hold;
        !rd_en |=> $stable(rd_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");
    property p_sym_hold;
        sym_valid && !sym_ready |=> sym_valid && $stable(sym_data);
    endproperty
    a_sym_hold: assert property (p_sym_hold)
        else $error("stalled symbol changed or vanished");
    property p_lock_excl;
        !(lock_lost_flag && lock_held_flag);
    endproperty
    a_lock_excl: assert property (p_lock_excl)
        else $error("both lock flags high");
    // half rate emits on every step, two cycles after the strobe
    property p_sym_lat;
        wr_en && addr == 5'h12 && ctrl_q == 3'h0 && !sym_valid
            |-> ##2 sym_valid;
    endproperty
    a_sym_lat: assert property (p_sym_lat)
        else $error("symbol late after encoder step");
    property p_ctrl_rb;
        rd_en && addr == 5'h06 |=> rd_data[2:0] == ctrl_q;
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb)
        else $error("control readback differs");
    property p_steps_clear;
        rd_en && addr == 5'h03 && (ctrl_q[2] || ctrl_q[1:0] == 2'h0)
            |=> rd_data[5:0] == 6'h00;
    endproperty
    a_steps_clear: assert property (p_steps_clear)
        else $error("step counter not at zero");
    property p_step_range;
        rd_en && addr == 5'h03 && ctrl_q == 3'h1
            |=> rd_data[2:0] <= 3'h2 && rd_data[5:3] <= 3'h2;
    endproperty
    a_step_range: assert property (p_step_range)
        else $error("three quarter step out of range");

    c_stall: cover property (sym_valid && !sym_ready [*3]);
    c_lost: cover property ($rose(lock_lost_flag));
    c_held: cover property ($rose(lock_held_flag));
endmodule

// [tb/symbol_sink.sv]
`timescale 1ns/100ps

// ****
// modulator model, takes symbols and may stall
// ****
module symbol_sink (
    input wire ref_clk,
    input wire rst,
    input wire want,
    input wire sym_valid,
    input wire [1:0] sym_data,
    output reg sym_ready
);
    logic [1:0] got[$]; // symbols in arrival order

    initial sym_ready = 1'b0;
    // readiness only moves off the sampling edge
    always @(negedge ref_clk) begin
        sym_ready <= want;
    end
    // a symbol leaves only on valid and ready together
    always @(posedge ref_clk) begin
        if (!rst && sym_valid && sym_ready) begin
            got.push_back(sym_data);
        end
    end
endmodule

// [tb/tb_punctured_rate_adapter.sv]
`timescale 1ns/100ps

module tb_punctured_rate_adapter;
    localparam [6:0] GEN_A = 7'h79; // first code bit taps
    localparam [6:0] GEN_B = 7'h5b; // second code bit taps
    logic ref_clk, rst, wr_en, rd_en, sym_ready, sym_valid, hold;
    logic want = 1'b0;
    logic lock_lost_flag, lock_held_flag, keep, b;
    logic [4:0] addr;
    logic [7:0] wr_data, rd_data, d;
    logic [1:0] sym_data, rt, p, pe;
    logic [6:0] sr, dsr; // model encoder histories, bit0 newest
    logic [2:0] st, rs; // model step counters
    logic [31:0] seed, stall_seed;
    logic [1:0] expq[$];
    logic info[$], dec[$];
    int fails, tests_run, cyc, i, k, n, sh, ph;
    bit ok;

    // ****
    // design, checker and far side
    // ****
    punctured_rate_adapter #(.LOCK_WIN(16'h0010), .LOCK_LIMIT(16'h0004))
    i_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .sym_ready(sym_ready), .sym_valid(sym_valid), .sym_data(sym_data),
        .lock_lost_flag(lock_lost_flag), .lock_held_flag(lock_held_flag));
    symbol_sink i_sink (.ref_clk(ref_clk), .rst(rst), .want(want),
        .sym_valid(sym_valid), .sym_data(sym_data), .sym_ready(sym_ready));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // random stalls, or a full stall while hold is set
    always @(negedge ref_clk) begin
        stall_seed = xs(stall_seed);
        want <= !hold && stall_seed[0];
    end
    // a hang ends the run as a failure
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [1:0] code(input logic [6:0] s);
        return {^(s & GEN_B), ^(s & GEN_A)};
    endfunction

    task final_report;
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (e !== g) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    // one idle cycle between accesses keeps strobes single-driven
    task wr(input logic [4:0] a, input logic [7:0] v);
        @(negedge ref_clk);
        addr = a;
        wr_data = v;
        wr_en = 1'b1;
        @(negedge ref_clk);
        wr_en = 1'b0;
    endtask
    task rd(input logic [4:0] a);
        @(negedge ref_clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge ref_clk);
        rd_en = 1'b0;
        d = rd_data;
    endtask
    task setc(input logic [7:0] v);
        wr(5'h06, v);
        rt = v[1:0];
        st = 3'h0;
        if (v[2]) sr = 7'h00;
    endtask
    // one encoder step; take is low where the step must be refused
    task enc(input logic bi, input logic take);
        wr(5'h05, {7'h00, bi});
        wr(5'h11, seed[7:0]);
        wr(5'h12, seed[15:8]);
        if (take) begin
            sr = {sr[5:0], bi};
            pe = code(sr);
            if (rt == 2'h0 || st == 3'h0) expq.push_back(pe);
            else if (st[0]) keep = pe[1];
            else expq.push_back({keep, (st == 3'h2 && rt == 2'h2) ?
                pe[1] : pe[0]});
            if (rt != 2'h0) st = (st == (rt == 2'h1 ? 3'h2 : 3'h6)) ?
                3'h0 : st + 3'h1;
        end
        rd(5'h02);
        chk("enc_pair", {6'h00, pe}, d);
        rd(5'h03);
        chk("tx_step", {5'h00, st}, {5'h00, d[2:0]});
    endtask
    task drain;
        for (k = 0; k < 60 && sym_valid !== 1'b0; k++) @(negedge ref_clk);
        chk("sym_count", 8'(expq.size()), 8'(i_sink.got.size()));
        while (expq.size() > 0 && i_sink.got.size() > 0)
            chk("symbol", {6'h00, expq.pop_front()},
                {6'h00, i_sink.got.pop_front()});
        expq.delete();
        i_sink.got.delete();
    endtask
    // pair bits: first, second, first erase, second erase
    task dstep(input logic [3:0] v);
        wr(5'h00, {4'h0, v});
        wr(5'h0e, seed[7:0]);
        wr(5'h0f, seed[15:8]);
        rd(5'h00);
        dec.push_back(d[0]);
    endtask

    // ****
    // main sequence
    // ****
    initial begin
        rst = 1'b1;
        {wr_en, rd_en, hold, keep, b} = 5'h00;
        {addr, wr_data, sr, dsr, st, rt, pe} = 34'h0;
        seed = 32'd17443;
        stall_seed = 32'd17443;
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        rd(5'h06);
        chk("ctrl_reset", 8'h00, d);
        rd(5'h03);
        chk("status_reset", 8'h00, d);
        rd(5'h1f);
        chk("unmapped", 8'h00, d);
        // every rate with random data and random stalls
        for (i = 0; i < 3; i++) begin
            setc(8'(i));
            repeat (14) begin
                seed = xs(seed);
                enc(seed[0], 1'b1);
            end
            drain();
        end
        // fill the buffer until the step strobe is refused
        setc(8'h00);
        hold = 1'b1;
        for (i = 0; i < 4; i++) enc(i[0], i < 3);
        rd(5'h03);
        chk("stall_flag", 8'h01, {7'h00, d[7]});
        hold = 1'b0;
        drain();
        // codec reset keeps host registers, ignores steps
        setc(8'h05);
        enc(1'b1, 1'b0);
        rd(5'h06);
        chk("ctrl_kept", 8'h05, d);
        setc(8'h01);
        repeat (6) begin
            seed = xs(seed);
            enc(seed[0], 1'b1);
        end
        drain();
        // clean half rate, then depunctured three quarter rate
        setc(8'h00);
        for (i = 0; i < 80; i++) begin
            seed = xs(seed);
            info.push_back(seed[0]);
            dsr = {dsr[5:0], seed[0]};
            p = code(dsr);
            if (i == 32) setc(8'h01);
            ph = i < 32 ? 0 : (i - 32) % 3;
            if (ph == 0) dstep({2'b00, p});
            else if (ph == 1) dstep({2'b01, p[1], seed[1]});
            else dstep({2'b10, seed[1], p[0]});
            if (i == 31) chk("lock_held", 8'h01,
                {6'h00, lock_lost_flag, lock_held_flag});
            if (i >= 32) begin
                rs = ph == 2 ? 3'h0 : 3'(ph + 1);
                rd(5'h03);
                chk("rx_step", {5'h00, rs}, {5'h00, d[5:3]});
            end
        end
        // garbage in the erased places must not disturb decoding
        sh = -1;
        for (k = 28; k <= 36; k++) begin
            ok = 1'b1;
            for (n = k; n < 80; n++) if (dec[n] !== info[n - k]) ok = 1'b0;
            if (ok && sh < 0) sh = k;
        end
        chk("dec_align", 8'h01, {7'h00, sh >= 0});
        // noise makes the decoder report lost lock
        setc(8'h00);
        repeat (48) begin
            seed = xs(seed);
            dstep({2'b00, seed[1:0]});
        end
        chk("lock_lost", 8'h02,
            {6'h00, lock_lost_flag, lock_held_flag});
        rd(5'h03);
        chk("status_lost", 8'h01, {7'h00, d[6]});
        final_report();
    end
endmodule

bind punctured_rate_adapter punctured_rate_adapter_properties i_props (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .sym_ready(sym_ready), .sym_valid(sym_valid), .sym_data(sym_data),
    .lock_lost_flag(lock_lost_flag), .lock_held_flag(lock_held_flag));
